//--- card_pins_cfg.svh
// Purpose: constants for the card host pin function logic
// Assumes: included by its bare name
// Notes: offsets and positions shared by package users and the top module
`ifndef CARD_PINS_CFG_SVH
`define CARD_PINS_CFG_SVH

`define CFG_ADDR_W 11
`define CFG_SYNC_W 20
`define CFG_SETTLE_EDGES 2'h2
`define CFG_ATTR_CONFIG_BIT 9
`define CFG_IDE_INDEX_W 3
`define CFG_IDE_DATA_INDEX 3'h0
`define CFG_IDE_CTRL_INDEX 3'h6
`define CFG_MODE_MEMORY 2'h0
`define CFG_MODE_IO 2'h1
`define CFG_MODE_IDE 2'h3

`endif

//--- card_pins_pkg.sv
// Purpose: types for the card host pin function logic
// Assumes: card_pins_cfg.svh supplies the encodings
// Notes: mode enum is gray along memory, io, ide
`include "card_pins_cfg.svh"

package card_pins_pkg;

    typedef enum logic [1:0] {
        MODE_MEMORY = `CFG_MODE_MEMORY,
        MODE_IO = `CFG_MODE_IO,
        MODE_IDE = `CFG_MODE_IDE
    } op_mode_t;

    typedef struct packed {
        logic [`CFG_SYNC_W-1:0] first;
        logic [`CFG_SYNC_W-1:0] second;
    } sync_state_t;

endpackage

//--- pin_sync.sv
// Purpose: two flip-flop synchroniser for all host pin inputs
// Assumes: pins are asynchronous to mclk
// Notes: only the second stage is visible outside
`timescale 1ns/1ns
`include "card_pins_cfg.svh"

module pin_sync
    import card_pins_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [`CFG_SYNC_W-1:0] pins,
    output logic [`CFG_SYNC_W-1:0] pins_sync
);

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb begin
        s_d.first = pins;
        s_d.second = s_q.first;
    end

    // idle level is all ones, matching inactive low-true pins
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign pins_sync = s_q.second;

endmodule

//--- card_host_pins.sv
// Purpose: mode dependent pin functions of a removable flash card host connector
// Assumes: 10 MHz mclk, synchronous active high reset from the card reset pin
// Notes: open-drain pins are out/oe pairs, oe high while driving low
`timescale 1ns/1ns
`include "card_pins_cfg.svh"

// Notes on behaviour
// - in both pc card modes the eleven address lines plus attribute select pick memory register, info structure or config registers; the io port only in io mode.
// - in true ide mode only the three low address bits pick one of eight task file registers and higher bits are ignored.
// - in memory mode the first battery detect output is held high.
// - in memory mode the second battery detect output is held high.
// - in io mode while the io interface is configured, status changed goes low to flag a ready or write protect change.
// - status changed is enabled or suppressed by the config and status register setting.
// - in io mode the audio output is held negated since binary audio is unsupported.
// - both card detect pins are ground in every mode.
// - in true ide mode the pass diagnostic pin is a two-way master/slave handshake signal.
// - in true ide mode the drive active/slave present pin is a two-way master/slave handshake signal.
// - in true ide mode the card is master when drive select is grounded and slave when it is open.
// - in true ide mode the first chip select enables the task file and the second the alternate status and device control.
// - in true ide mode task file accesses are bytes on the low lane and data transfers are 16-bit words.
module card_host_pins
    import card_pins_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [`CFG_ADDR_W-1:0] host_address_lines,
    input wire logic attribute_select_n,
    input wire logic io_strobe_n,
    input wire logic task_file_select_n,
    input wire logic control_block_select_n,
    input wire logic drive_role_select_n,
    input wire logic ide_strap_n,
    input wire logic io_strap,
    input wire logic pass_diagnostic_n_in,
    input wire logic drive_active_present_n_in,
    input wire logic io_configured,
    input wire logic status_change_enable,
    input wire logic ready_changed,
    input wire logic write_protect_changed,
    input wire logic status_ack,
    input wire logic diag_passed,
    input wire logic drive_busy,
    output logic mode_valid,
    output op_mode_t op_mode,
    output logic drive_is_master,
    output logic pc_io_port_sel,
    output logic pc_mem_reg_sel,
    output logic pc_cis_sel,
    output logic pc_config_sel,
    output logic [`CFG_ADDR_W-1:0] pc_reg_offset,
    output logic ide_tf_sel,
    output logic ide_ctrl_sel,
    output logic [`CFG_IDE_INDEX_W-1:0] ide_reg_index,
    output logic ide_word_access,
    output logic slave_present,
    output logic slave_diag_ok,
    output logic pin45_out,
    output logic pin45_oe,
    output logic pin46_out,
    output logic pin46_oe,
    output logic card_detect_first_n,
    output logic card_detect_second_n
);

    typedef struct packed {
        logic latched;
        logic [1:0] settle;
        op_mode_t mode;
        logic master;
        logic stat_pend;
        logic announce;
        logic io_sel;
        logic mem_sel;
        logic cis_sel;
        logic cfg_sel;
        logic [`CFG_ADDR_W-1:0] offset;
        logic tf_sel;
        logic ctrl_sel;
        logic [`CFG_IDE_INDEX_W-1:0] index;
        logic word;
        logic present;
        logic diag_ok;
        logic p45_out;
        logic p45_oe;
        logic p46_out;
        logic p46_oe;
    } pins_state_t;

    pins_state_t s_q;
    pins_state_t s_d;
    logic [`CFG_SYNC_W-1:0] raw;
    logic [`CFG_SYNC_W-1:0] syn;

    assign raw = {host_address_lines, attribute_select_n, io_strobe_n, task_file_select_n,
                  control_block_select_n, drive_role_select_n, ide_strap_n, io_strap,
                  pass_diagnostic_n_in, drive_active_present_n_in};

    pin_sync u_sync (
        .mclk(mclk),
        .reset(reset),
        .pins(raw),
        .pins_sync(syn)
    );

    logic [`CFG_ADDR_W-1:0] addr_s;
    logic attr_n_s;
    logic io_strb_n_s;
    logic cs0_n_s;
    logic cs1_n_s;
    logic role_n_s;
    logic ide_strap_n_s;
    logic io_strap_s;
    logic pass_diagnostic_n_n_s;
    logic drive_active_present_n_n_s;

    assign {addr_s, attr_n_s, io_strb_n_s, cs0_n_s, cs1_n_s, role_n_s, ide_strap_n_s,
            io_strap_s, pass_diagnostic_n_n_s, drive_active_present_n_n_s} = syn;

    logic is_ide;
    logic is_io;
    logic is_mem;
    logic io_cycle;

    assign is_ide = s_q.latched && (s_q.mode == MODE_IDE);
    assign is_io = s_q.latched && (s_q.mode == MODE_IO);
    assign is_mem = s_q.latched && (s_q.mode == MODE_MEMORY);
    assign io_cycle = is_io && !io_strb_n_s && !attr_n_s;

    always_comb begin
        s_d = s_q;
        // straps are taken once after release; later pin motion cannot re-map pins
        // the synchroniser leaves reset full of ones, so wait until real pin levels arrive
        if (!s_q.latched) begin
            if (s_q.settle != `CFG_SETTLE_EDGES) begin
                s_d.settle = s_q.settle + 2'h1;
            end else begin
                s_d.latched = 1'b1;
                if (!ide_strap_n_s) begin
                    s_d.mode = MODE_IDE;
                end else if (io_strap_s) begin
                    s_d.mode = MODE_IO;
                end else begin
                    s_d.mode = MODE_MEMORY;
                end
                s_d.master = !role_n_s;
                s_d.announce = role_n_s;
            end
        end
        // pc card decode on full address and attribute select
        s_d.io_sel = io_cycle;
        s_d.mem_sel = (is_mem || is_io) && attr_n_s;
        s_d.cis_sel = (is_mem || is_io) && !attr_n_s && !io_cycle
                      && !addr_s[`CFG_ATTR_CONFIG_BIT];
        s_d.cfg_sel = (is_mem || is_io) && !attr_n_s && !io_cycle
                      && addr_s[`CFG_ATTR_CONFIG_BIT];
        s_d.offset = (is_ide) ? '0 : addr_s;
        // upper address bits never reach the ide decode
        s_d.index = is_ide ? addr_s[`CFG_IDE_INDEX_W-1:0] : '0;
        s_d.tf_sel = is_ide && !cs0_n_s;
        s_d.ctrl_sel = is_ide && !cs1_n_s
                       && (addr_s[`CFG_IDE_INDEX_W-1:0] == `CFG_IDE_CTRL_INDEX);
        s_d.word = is_ide && !cs0_n_s
                   && (addr_s[`CFG_IDE_INDEX_W-1:0] == `CFG_IDE_DATA_INDEX);
        // set wins over the acknowledge so a change in the ack cycle is kept
        if (ready_changed || write_protect_changed) begin
            s_d.stat_pend = 1'b1;
        end else if (status_ack) begin
            s_d.stat_pend = 1'b0;
        end
        if (s_q.latched && diag_passed) begin
            s_d.announce = 1'b0;
        end
        s_d.present = is_ide && s_q.master && !drive_active_present_n_n_s;
        s_d.diag_ok = is_ide && s_q.master && !pass_diagnostic_n_n_s;
        s_d.p45_out = 1'b1;
        s_d.p45_oe = 1'b0;
        s_d.p46_out = 1'b1;
        s_d.p46_oe = 1'b0;
        case (s_q.mode)
            MODE_MEMORY: begin
                s_d.p46_oe = s_q.latched;
                s_d.p45_oe = s_q.latched;
            end
            MODE_IO: begin
                s_d.p45_oe = s_q.latched;
                s_d.p46_oe = s_q.latched;
                s_d.p46_out = !(io_configured && status_change_enable
                                && s_q.stat_pend);
            end
            MODE_IDE: begin
                // open drain: only ever pulled low, the pull-up gives the high
                s_d.p45_out = 1'b0;
                s_d.p45_oe = s_q.latched && (drive_busy
                             || (!s_q.master && s_q.announce));
                s_d.p46_out = 1'b0;
                s_d.p46_oe = s_q.latched && !s_q.master && diag_passed;
            end
            default: begin
                s_d.p45_oe = 1'b0;
                s_d.p46_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= '0;
            s_q.mode <= MODE_MEMORY;
            s_q.p45_out <= 1'b1;
            s_q.p46_out <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign mode_valid = s_q.latched;
    assign op_mode = s_q.mode;
    assign drive_is_master = s_q.master;
    assign pc_io_port_sel = s_q.io_sel;
    assign pc_mem_reg_sel = s_q.mem_sel;
    assign pc_cis_sel = s_q.cis_sel;
    assign pc_config_sel = s_q.cfg_sel;
    assign pc_reg_offset = s_q.offset;
    assign ide_tf_sel = s_q.tf_sel;
    assign ide_ctrl_sel = s_q.ctrl_sel;
    assign ide_reg_index = s_q.index;
    assign ide_word_access = s_q.word;
    assign slave_present = s_q.present;
    assign slave_diag_ok = s_q.diag_ok;
    assign pin45_out = s_q.p45_out;
    assign pin45_oe = s_q.p45_oe;
    assign pin46_out = s_q.p46_out;
    assign pin46_oe = s_q.p46_oe;
    // card detect is plain ground, so no state is needed
    assign card_detect_first_n = 1'b0;
    assign card_detect_second_n = 1'b0;

    a_mode_frozen: assert property (@(posedge mclk) disable iff (reset)
        mode_valid && $past(mode_valid) |-> $stable(op_mode) && $stable(drive_is_master))
        else $error("latched mode changed");
    a_mem_battery: assert property (@(posedge mclk) disable iff (reset)
        is_mem ##1 is_mem |-> pin46_oe && pin46_out && pin45_oe && pin45_out)
        else $error("battery detect not high in memory mode");
    a_io_audio: assert property (@(posedge mclk) disable iff (reset)
        is_io ##1 is_io |-> pin45_oe && pin45_out)
        else $error("audio line not negated");
    a_status_alert: assert property (@(posedge mclk) disable iff (reset)
        is_io && io_configured && status_change_enable && ready_changed
        ##1 (io_configured && status_change_enable) |=> !pin46_out)
        else $error("status change not flagged");
    a_status_mask: assert property (@(posedge mclk) disable iff (reset)
        is_io && !status_change_enable |=> pin46_out)
        else $error("status change not suppressed");
    a_tf_decode: assert property (@(posedge mclk) disable iff (reset)
        is_ide && !cs0_n_s |=> ide_tf_sel && ide_reg_index == $past(addr_s[2:0]))
        else $error("task file decode wrong");
    a_ide_word: assert property (@(posedge mclk) disable iff (reset)
        ide_word_access |-> ide_tf_sel && ide_reg_index == `CFG_IDE_DATA_INDEX)
        else $error("word access outside data register");
    a_pc_decode: assert property (@(posedge mclk) disable iff (reset)
        (is_mem || is_io) && !attr_n_s && !io_cycle |=>
        (pc_config_sel == $past(addr_s[`CFG_ATTR_CONFIG_BIT])) && (pc_cis_sel != pc_config_sel))
        else $error("attribute decode wrong");
    a_ide_od: assert property (@(posedge mclk) disable iff (reset)
        is_ide ##1 is_ide |-> !pin45_out && !pin46_out)
        else $error("handshake pin driven high");
    a_pc_quiet_ide: assert property (@(posedge mclk) disable iff (reset)
        is_ide ##1 is_ide |-> !pc_io_port_sel && !pc_mem_reg_sel && !pc_cis_sel)
        else $error("pc decode active in ide mode");

endmodule

//--- host_model.sv
// Purpose: host socket side of card_host_pins: address lines and shared handshake wires
// Assumes: both handshake wires carry pull-ups, so a released wire reads high
// Notes: peer pulls stand for the second drive on the cable
`timescale 1ns/1ns

module host_model (
    input wire logic [10:0] req_address,
    input wire logic ide_mode,
    input wire logic pin45_out,
    input wire logic pin45_oe,
    input wire logic pin46_out,
    input wire logic pin46_oe,
    input wire logic peer_pull45,
    input wire logic peer_pull46,
    input wire logic card_detect_first_n,
    input wire logic card_detect_second_n,
    output logic [10:0] host_address_lines,
    output logic active_wire,
    output logic diag_wire,
    output logic card_inserted
);
    // upper lines grounded in ide mode, so only the low three can vary
    assign host_address_lines = ide_mode ? {8'h00, req_address[2:0]} : req_address;
    // only a low is ever driven; the pull-up wins otherwise
    assign active_wire = !((pin45_oe && !pin45_out) || peer_pull45);
    assign diag_wire = !((pin46_oe && !pin46_out) || peer_pull46);
    assign card_inserted = !card_detect_first_n && !card_detect_second_n;
endmodule

//--- testbench.sv
// Purpose: self-checking bench for card_host_pins in all three modes
// Assumes: design assertions sit in the design files
// Notes: decode checks wait four edges: two sync stages, the output flop and one spare edge
`timescale 1ns/1ns

module testbench
    import card_pins_pkg::*;
;
    logic mclk, reset, attribute_select_n, io_strobe_n, task_file_select_n;
    logic control_block_select_n, drive_role_select_n, ide_strap_n, io_strap;
    logic io_configured, status_change_enable, ready_changed, write_protect_changed;
    logic status_ack, diag_passed, drive_busy, peer_pull45, peer_pull46;
    logic active_wire, diag_wire, card_inserted, mode_valid, drive_is_master;
    logic pc_io_port_sel, pc_mem_reg_sel, pc_cis_sel, pc_config_sel, ide_tf_sel;
    logic ide_ctrl_sel, ide_word_access, slave_present, slave_diag_ok;
    logic pin45_out, pin45_oe, pin46_out, pin46_oe, card_detect_first_n, card_detect_second_n;
    logic [10:0] req_address, host_address_lines, pc_reg_offset;
    logic [2:0] ide_reg_index;
    op_mode_t op_mode;
    int fails, samples_checked;

    card_host_pins DUT (.mclk, .reset, .host_address_lines, .attribute_select_n, .io_strobe_n,
        .task_file_select_n, .control_block_select_n, .drive_role_select_n, .ide_strap_n,
        .io_strap, .pass_diagnostic_n_in(diag_wire), .drive_active_present_n_in(active_wire),
        .io_configured, .status_change_enable, .ready_changed, .write_protect_changed,
        .status_ack, .diag_passed, .drive_busy, .mode_valid, .op_mode, .drive_is_master,
        .pc_io_port_sel, .pc_mem_reg_sel, .pc_cis_sel, .pc_config_sel, .pc_reg_offset,
        .ide_tf_sel, .ide_ctrl_sel, .ide_reg_index, .ide_word_access, .slave_present,
        .slave_diag_ok, .pin45_out, .pin45_oe, .pin46_out, .pin46_oe, .card_detect_first_n,
        .card_detect_second_n);

    host_model PEER (.req_address, .ide_mode(!ide_strap_n), .pin45_out, .pin45_oe, .pin46_out,
        .pin46_oe, .peer_pull45, .peer_pull46, .card_detect_first_n, .card_detect_second_n,
        .host_address_lines, .active_wire, .diag_wire, .card_inserted);

    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // inputs always change 2 ns after an edge, well clear of sampling
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    // straps settle long before release so the latch sees them through the synchroniser
    task automatic boot(input logic ide_n, input logic io, input logic role_n);
        ide_strap_n = ide_n;
        io_strap = io;
        drive_role_select_n = role_n;
        reset = 1;
        tick(6);
        reset = 0;
        tick(5);
        chk("mode_valid", 1, mode_valid);
        chk("card_detect", 0, {card_detect_first_n, card_detect_second_n});
        chk("inserted", 1, card_inserted);
    endtask

    task automatic pulse_alert(input logic wp, input logic [1:0] exp);
        ready_changed = !wp;
        write_protect_changed = wp;
        tick(1);
        ready_changed = 0;
        write_protect_changed = 0;
        tick(2);
        chk("alert", exp, {pin46_out, pin46_oe});
    endtask

    task automatic test_memory();
        boot(1, 0, 0);
        chk("op_mode", MODE_MEMORY, op_mode);
        chk("pin46", 2'h3, {pin46_out, pin46_oe});
        chk("pin45", 2'h3, {pin45_out, pin45_oe});
        attribute_select_n = 0;
        req_address = 11'h2A5;
        tick(4);
        chk("cfg_cis", 2'h2, {pc_config_sel, pc_cis_sel});
        chk("offset", 11'h2A5, pc_reg_offset);
        req_address = 11'h5A5;
        tick(4);
        chk("cfg_cis", 2'h1, {pc_config_sel, pc_cis_sel});
        attribute_select_n = 1;
        task_file_select_n = 0;
        tick(4);
        chk("mem_io_tf", 3'h4, {pc_mem_reg_sel, pc_io_port_sel, ide_tf_sel});
        task_file_select_n = 1;
        $display("test_memory done");
    endtask

    task automatic test_io();
        boot(1, 1, 0);
        chk("op_mode", MODE_IO, op_mode);
        chk("audio", 2'h3, {pin45_out, pin45_oe});
        io_strobe_n = 0;
        attribute_select_n = 0;
        tick(4);
        chk("io_port", 1, pc_io_port_sel);
        io_strobe_n = 1;
        pulse_alert(0, 2'h3);
        io_configured = 1;
        status_change_enable = 1;
        pulse_alert(0, 2'h1);
        status_ack = 1;
        tick(1);
        status_ack = 0;
        tick(2);
        chk("alert_ack", 2'h3, {pin46_out, pin46_oe});
        pulse_alert(1, 2'h1);
        status_change_enable = 0;
        tick(2);
        chk("alert_off", 2'h3, {pin46_out, pin46_oe});
        status_ack = 1;
        tick(1);
        status_ack = 0;
        pulse_alert(0, 2'h3);
        status_ack = 1;
        tick(1);
        status_ack = 0;
        status_change_enable = 1;
        tick(3);
        chk("alert_idle", 2'h3, {pin46_out, pin46_oe});
        io_configured = 0;
        $display("test_io done");
    endtask

    task automatic test_ide_master();
        boot(0, 0, 0);
        chk("op_mode", MODE_IDE, op_mode);
        chk("master", 1, drive_is_master);
        task_file_select_n = 0;
        for (int i = 0; i < 8; i++) begin
            req_address = 11'h7F8 | 11'(i);
            tick(4);
            chk("tf", {1'b1, i == 0, 3'(i)}, {ide_tf_sel, ide_word_access, ide_reg_index});
            chk("pc_sel", 0, {pc_io_port_sel, pc_mem_reg_sel, pc_cis_sel, pc_config_sel});
        end
        task_file_select_n = 1;
        control_block_select_n = 0;
        req_address = 11'h006;
        tick(4);
        chk("ctrl", 2'h2, {ide_ctrl_sel, ide_tf_sel});
        req_address = 11'h005;
        tick(4);
        chk("ctrl", 0, {ide_ctrl_sel, ide_tf_sel});
        control_block_select_n = 1;
        peer_pull45 = 1;
        tick(4);
        chk("present", 2'h2, {slave_present, slave_diag_ok});
        peer_pull46 = 1;
        peer_pull45 = 0;
        tick(4);
        chk("diag_ok", 2'h1, {slave_present, slave_diag_ok});
        peer_pull46 = 0;
        $display("test_ide_master done");
    endtask

    task automatic test_ide_slave();
        boot(0, 0, 1);
        chk("master", 0, drive_is_master);
        chk("pins", 3'h2, {pin45_out, pin45_oe, pin46_oe});
        diag_passed = 1;
        tick(3);
        chk("pins", 2'h1, {pin45_oe, pin46_out, pin46_oe});
        drive_busy = 1;
        tick(3);
        chk("busy", 2'h1, {pin45_out, pin45_oe});
        $display("test_ide_slave done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        #(5000 * 100);
        fails++;
        $display("[ERR] watchdog expected finish seen hang");
        stop_test();
    end

    initial begin
        {reset, attribute_select_n, io_strobe_n, task_file_select_n} = 4'hF;
        {control_block_select_n, drive_role_select_n, ide_strap_n, io_strap} = 4'hE;
        {io_configured, status_change_enable, ready_changed, write_protect_changed} = 4'h0;
        {status_ack, diag_passed, drive_busy, peer_pull45, peer_pull46} = 5'h00;
        req_address = 11'h000;
        fails = 0;
        samples_checked = 0;
        test_memory();
        test_io();
        test_ide_master();
        test_ide_slave();
        stop_test();
    end
endmodule
